// [design/ormn_pkg.sv]
// Package with encodings, field positions and reset values for the OR/move/idle executor.
`default_nettype none
package ormn_pkg;
  // ****************************************
  // Instruction encodings
  // ****************************************
  localparam int unsigned WORD_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IDX_W = 5;
  localparam logic [3:0] OP_OR_LITERAL = 4'hd;
  localparam logic [3:0] OP_LOAD_LITERAL = 4'hc;
  localparam logic [5:0] OP_OR_REGISTER = 6'h04;
  localparam logic [5:0] OP_COPY_REGISTER = 6'h08;
  localparam logic [6:0] OP_STORE_ACC = 7'h01;
  localparam logic [11:0] OP_IDLE = 12'h000;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned TARGET_BIT = 5;
  localparam int unsigned NIBBLE_LSB = 8;
  localparam int unsigned SIX_LSB = 6;
  localparam int unsigned SEVEN_LSB = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic NULL_FLAG_RESET = 1'b0;
  localparam int unsigned FILE_DEPTH = 32;
  typedef enum logic [2:0] {
    ORMN_IDLE, ORMN_OR_LIT, ORMN_LOAD_LIT, ORMN_OR_REG, ORMN_COPY_REG, ORMN_STORE_ACC, ORMN_OTHER
  } ormn_op_t;
endpackage : ormn_pkg
`default_nettype wire

// [design/ormn_file_mem.sv]
// Small file register array with registered read data.
`timescale 1ns/1ns
`default_nettype none
module ormn_file_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned DW = 8,
  parameter int unsigned AW = 5
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  // A depth beyond the index range would leave entries that no word can ever reach.
  if (DEPTH > (1 << AW)) begin : g_depth_check
    $error("ormn_file_mem depth exceeds address range");
  end
  logic [DW-1:0] mem [DEPTH];
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule : ormn_file_mem
`default_nettype wire

// [design/ormn_core.sv]
// Executor for OR literal, OR register, copy register, store accumulator, load literal and idle words.
// How it works
// - A word with top nibble 1101 ORs its low byte into the accumulator and sets the zero flag from the result.
// - A word starting 0001 00 ORs the accumulator with the indexed file register and sets the zero flag.
// - The target bit sends a register-operand result to the accumulator when 0 and to the file register when 1.
// - A word starting 0010 00 copies the indexed file register to the accumulator or back to itself.
// - The copy sets the zero flag from the moved value and touches no other status.
// - A copy back to the same register leaves its value as it was but still sets the zero flag.
// - A word starting 0000 001 stores the accumulator into the indexed file register and leaves flags alone.
// - A word with top nibble 1100 loads its low byte into the accumulator and leaves flags alone.
`timescale 1ns/1ns
`default_nettype none
module ormn_core (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic instr_valid_i,
  input wire logic [11:0] instr_word_i,
  output logic [7:0] acc_o,
  output logic null_result_flag_o,
  output logic file_we_o,
  output logic [4:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic done_o,
  output logic unknown_o
);
  // ****************************************
  // Two-phase execution: phase A reads the file register, phase B retires.
  // ****************************************
  // The memory read is registered, so every word takes two clock edges; the core's
  // instruction clock is taken as this pair, so each word still retires in one cycle.
  typedef enum logic {ORMN_PH_FETCH, ORMN_PH_EXEC} ormn_phase_t;
  ormn_phase_t phase;
  logic [11:0] word;
  logic [7:0] file_rdata;
  ormn_pkg::ormn_op_t op;
  logic target;
  logic [4:0] idx;
  logic [7:0] lit;
  logic [7:0] result;
  logic next_file_we;

  assign target = word[ormn_pkg::TARGET_BIT];
  assign idx = word[4:0];
  assign lit = word[7:0];

  always_comb begin
    if (word == ormn_pkg::OP_IDLE) begin
      op = ormn_pkg::ORMN_IDLE;
    end else if (word[11:ormn_pkg::NIBBLE_LSB] == ormn_pkg::OP_OR_LITERAL) begin
      op = ormn_pkg::ORMN_OR_LIT;
    end else if (word[11:ormn_pkg::NIBBLE_LSB] == ormn_pkg::OP_LOAD_LITERAL) begin
      op = ormn_pkg::ORMN_LOAD_LIT;
    end else if (word[11:ormn_pkg::SIX_LSB] == ormn_pkg::OP_OR_REGISTER) begin
      op = ormn_pkg::ORMN_OR_REG;
    end else if (word[11:ormn_pkg::SIX_LSB] == ormn_pkg::OP_COPY_REGISTER) begin
      op = ormn_pkg::ORMN_COPY_REG;
    end else if (word[11:ormn_pkg::SEVEN_LSB] == ormn_pkg::OP_STORE_ACC) begin
      op = ormn_pkg::ORMN_STORE_ACC;
    end else begin
      op = ormn_pkg::ORMN_OTHER;
    end
  end

  always_comb begin
    case (op)
      ormn_pkg::ORMN_OR_LIT: result = acc_o | lit;
      ormn_pkg::ORMN_LOAD_LIT: result = lit;
      ormn_pkg::ORMN_OR_REG: result = acc_o | file_rdata;
      ormn_pkg::ORMN_COPY_REG: result = file_rdata;
      ormn_pkg::ORMN_STORE_ACC: result = acc_o;
      default: result = acc_o;
    endcase
  end

  // The array is written on the execute edge itself, so a word taken on the very next edge
  // already reads the new value; a write one edge later would hand that word stale data.
  always_comb begin
    next_file_we = 1'b0;
    if (rst_b_i && phase == ORMN_PH_EXEC) begin
      if (op == ormn_pkg::ORMN_STORE_ACC) begin
        next_file_we = 1'b1;
      end else if ((op == ormn_pkg::ORMN_OR_REG || op == ormn_pkg::ORMN_COPY_REG) && target) begin
        next_file_we = 1'b1;
      end
    end
  end

  // ****************************************
  // Sequencing
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      phase <= ORMN_PH_FETCH;
      word <= ormn_pkg::OP_IDLE;
    end else if (phase == ORMN_PH_FETCH) begin
      if (instr_valid_i) begin
        phase <= ORMN_PH_EXEC;
        word <= instr_word_i;
      end
    end else begin
      phase <= ORMN_PH_FETCH;
    end
  end

  ormn_file_mem #(.DEPTH(ormn_pkg::FILE_DEPTH), .DW(8), .AW(5)) u_mem (
    .clk_sys_i(clk_sys_i),
    .we_i(next_file_we),
    .waddr_i(idx),
    .wdata_i(result),
    .raddr_i(instr_word_i[4:0]),
    .rdata_o(file_rdata)
  );

  // ****************************************
  // Accumulator and zero flag
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      acc_o <= ormn_pkg::ACC_RESET;
    end else if (phase == ORMN_PH_EXEC) begin
      if (op == ormn_pkg::ORMN_OR_LIT || op == ormn_pkg::ORMN_LOAD_LIT) begin
        acc_o <= result;
      end else if ((op == ormn_pkg::ORMN_OR_REG || op == ormn_pkg::ORMN_COPY_REG) && !target) begin
        acc_o <= result;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      null_result_flag_o <= ormn_pkg::NULL_FLAG_RESET;
    end else if (phase == ORMN_PH_EXEC) begin
      if (op == ormn_pkg::ORMN_OR_LIT || op == ormn_pkg::ORMN_OR_REG || op == ormn_pkg::ORMN_COPY_REG) begin
        null_result_flag_o <= (result == 8'h00);
      end
    end
  end

  // ****************************************
  // File write port, one-cycle pulse
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      file_we_o <= 1'b0;
      file_addr_o <= 5'h00;
      file_wdata_o <= 8'h00;
    end else begin
      // A self-copy writes back the value just read, so the register keeps its content.
      file_we_o <= next_file_we;
      if (phase == ORMN_PH_EXEC) begin
        file_addr_o <= idx;
        file_wdata_o <= result;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      unknown_o <= 1'b0;
    end else begin
      done_o <= (phase == ORMN_PH_EXEC);
      unknown_o <= (phase == ORMN_PH_EXEC) && (op == ormn_pkg::ORMN_OTHER);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_or_lit;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_OR_LIT) |=> acc_o == ($past(acc_o) | $past(lit))
      && null_result_flag_o == (acc_o == 8'h00);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("OR literal result wrong");
  property p_or_reg;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_OR_REG) |=> null_result_flag_o == ($past(result) == 8'h00);
  endproperty
  a_or_reg: assert property (p_or_reg) else $error("OR register flag wrong");
  property p_target;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && (op == ormn_pkg::ORMN_OR_REG || op == ormn_pkg::ORMN_COPY_REG))
      |=> file_we_o == $past(target) && (!file_we_o || $stable(acc_o));
  endproperty
  a_target: assert property (p_target) else $error("Target routing wrong");
  property p_copy;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_COPY_REG && !target) |=> acc_o == $past(file_rdata);
  endproperty
  a_copy: assert property (p_copy) else $error("Copy to accumulator wrong");
  property p_copy_flag;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_COPY_REG) |=> null_result_flag_o == ($past(file_rdata) == 8'h00);
  endproperty
  a_copy_flag: assert property (p_copy_flag) else $error("Copy flag wrong");
  property p_self;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_COPY_REG && target) |=> file_wdata_o == $past(file_rdata);
  endproperty
  a_self: assert property (p_self) else $error("Self copy changed value");
  property p_store;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_STORE_ACC)
      |=> file_we_o && file_wdata_o == $past(acc_o) && $stable(null_result_flag_o);
  endproperty
  a_store: assert property (p_store) else $error("Store accumulator wrong");
  property p_load;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_LOAD_LIT) |=> acc_o == $past(lit) && $stable(null_result_flag_o);
  endproperty
  a_load: assert property (p_load) else $error("Load literal wrong");
  property p_idle;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_IDLE)
      |=> $stable(acc_o) && $stable(null_result_flag_o) && !file_we_o;
  endproperty
  a_idle: assert property (p_idle) else $error("Idle word changed state");
  property p_one_cycle;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (phase == ORMN_PH_FETCH && instr_valid_i) |=> ##1 done_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("Word did not retire in time");
  c_or_reg_file: cover property (@(posedge clk_sys_i) phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_OR_REG && target);
  c_self_zero: cover property (@(posedge clk_sys_i) phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_COPY_REG
    && target && file_rdata == 8'h00);
  c_store: cover property (@(posedge clk_sys_i) phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_STORE_ACC);
  c_or_lit_zero: cover property (@(posedge clk_sys_i) phase == ORMN_PH_EXEC && op == ormn_pkg::ORMN_OR_LIT
    && result == 8'h00);
endmodule : ormn_core
`default_nettype wire

// [verif/ormn_fetch_model.sv]
// Instruction fetch model that offers one word at a time to the executor.
`timescale 1ns/1ns
`default_nettype none
module ormn_fetch_model (
  input wire logic clk_sys_i,
  input wire logic done_i,
  output logic instr_valid_o,
  output logic [11:0] instr_word_o
);
  initial begin
    instr_valid_o = 1'b0;
    instr_word_o = 12'h000;
  end
  // Edges counted after the take edge up to the one that launches done; 99 means the word never retired.
  task automatic wait_done(output int lat);
    lat = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      lat++;
    end while (done_i !== 1'b1 && lat < 8);
    if (done_i !== 1'b1) begin
      lat = 99;
    end
  endtask : wait_done
  // A released word bus shows the inverse of the last word, so a late sample cannot match by luck.
  task automatic issue(input logic [11:0] word, output int lat);
    @(negedge clk_sys_i);
    instr_valid_o = 1'b1;
    instr_word_o = word;
    @(negedge clk_sys_i);
    instr_valid_o = 1'b0;
    instr_word_o = ~word;
    wait_done(lat);
  endtask : issue
  // Valid stays high; the second word is already offered in the execute cycle, where it must be ignored.
  task automatic burst(input logic [11:0] w0, input logic [11:0] w1, output int lat);
    @(negedge clk_sys_i);
    instr_valid_o = 1'b1;
    instr_word_o = w0;
    @(negedge clk_sys_i);
    instr_word_o = w1;
    repeat (2) @(negedge clk_sys_i);
    instr_valid_o = 1'b0;
    instr_word_o = ~w1;
    wait_done(lat);
  endtask : burst
endmodule : ormn_fetch_model
`default_nettype wire

// [verif/ormn_core_tb_top.sv]
// Self-checking bench for the OR, move and idle executor.
`timescale 1ns/1ns
`default_nettype none
module ormn_core_tb_top;
  typedef struct packed {
    logic [11:0] word;
    logic [7:0] acc;
    logic flag;
    logic we;
    logic [7:0] wdata;
    logic unk;
  } ormn_row_t;
  logic clk_sys_i, rst_b_i, instr_valid, flag, we, done, unk;
  logic [11:0] instr_word;
  logic [7:0] acc, wdata;
  logic [4:0] addr;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int lat;
  // ****************************************
  // Word, accumulator, flag, write, write data, unknown
  // ****************************************
  ormn_row_t rows [22] = '{
    '{12'hc91, 8'h91, 1'b0, 1'b0, 8'h00, 1'b0}, '{12'h02a, 8'h91, 1'b0, 1'b1, 8'h91, 1'b0},
    '{12'hc13, 8'h13, 1'b0, 1'b0, 8'h00, 1'b0}, '{12'h10a, 8'h93, 1'b0, 1'b0, 8'h00, 1'b0},
    '{12'h02b, 8'h93, 1'b0, 1'b1, 8'h93, 1'b0}, '{12'hc00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
    '{12'hd00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0}, '{12'hc00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
    '{12'hd35, 8'h35, 1'b0, 1'b0, 8'h00, 1'b0}, '{12'h000, 8'h35, 1'b0, 1'b0, 8'h00, 1'b0},
    '{12'h12a, 8'h35, 1'b0, 1'b1, 8'hb5, 1'b0}, '{12'h20a, 8'hb5, 1'b0, 1'b0, 8'h00, 1'b0},
    '{12'h03f, 8'hb5, 1'b0, 1'b1, 8'hb5, 1'b0}, '{12'hc00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
    '{12'h03e, 8'h00, 1'b0, 1'b1, 8'h00, 1'b0}, '{12'h11e, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
    '{12'h21f, 8'hb5, 1'b0, 1'b0, 8'h00, 1'b0}, '{12'hcff, 8'hff, 1'b0, 1'b0, 8'h00, 1'b0},
    '{12'h23e, 8'hff, 1'b1, 1'b1, 8'h00, 1'b0}, '{12'h000, 8'hff, 1'b1, 1'b0, 8'h00, 1'b0},
    '{12'h03c, 8'hff, 1'b1, 1'b1, 8'hff, 1'b0}, '{12'h3ff, 8'hff, 1'b1, 1'b0, 8'h00, 1'b1}};
  ormn_core DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid),
    .instr_word_i(instr_word), .acc_o(acc), .null_result_flag_o(flag), .file_we_o(we),
    .file_addr_o(addr), .file_wdata_o(wdata), .done_o(done), .unknown_o(unk));
  ormn_fetch_model u_fetch (.clk_sys_i(clk_sys_i), .done_i(done), .instr_valid_o(instr_valid),
    .instr_word_o(instr_word));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %0s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit
  task automatic chk_idx(input logic [4:0] got, input logic [4:0] exp, input string what);
    chk_byte({3'h0, got}, {3'h0, exp}, what);
  endtask : chk_idx
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // The whole run needs well under 200 cycles; the ceiling only cuts a hang short.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk_byte(acc, 8'h00, "acc in reset");
    chk_bit(flag, 1'b0, "flag in reset");
    rst_b_i = 1'b1;
    for (int i = 0; i < 22; i++) begin
      u_fetch.issue(rows[i].word, lat);
      chk_byte(8'(lat), 8'h01, "latency");
      chk_byte(acc, rows[i].acc, "acc");
      chk_bit(flag, rows[i].flag, "flag");
      chk_bit(we, rows[i].we, "write");
      chk_bit(unk, rows[i].unk, "unknown");
      if (rows[i].we) begin
        chk_byte(wdata, rows[i].wdata, "wdata");
        chk_idx(addr, rows[i].word[4:0], "addr");
      end
    end
    $display("test table done");
    u_fetch.issue(12'hc77, lat);
    chk_byte(acc, 8'h77, "acc before reset");
    @(negedge clk_sys_i);
    rst_b_i = 1'b0;
    @(negedge clk_sys_i);
    chk_byte(acc, 8'h00, "acc after mid reset");
    chk_bit(flag, 1'b0, "flag after mid reset");
    chk_bit(done, 1'b0, "done after mid reset");
    rst_b_i = 1'b1;
    $display("test mid reset done");
    u_fetch.issue(12'hc40, lat);
    u_fetch.burst(12'hd01, 12'h025, lat);
    chk_byte(8'(lat), 8'h01, "back to back latency");
    chk_byte(acc, 8'h41, "back to back acc");
    chk_bit(we, 1'b1, "back to back write");
    chk_byte(wdata, 8'h41, "back to back wdata");
    chk_idx(addr, 5'h05, "back to back addr");
    $display("test back to back done");
    end_of_test();
  end
endmodule : ormn_core_tb_top
`default_nettype wire
